// *** fqm_pkg.sv ***
// package: descriptor layout, command and entry types, constants
package fqm_pkg;
  localparam int FD_BYTES = 16;
  localparam int FQ_IDX_W = 8;
  localparam int WQ_PER_CHAN = 8;
  localparam int DQR_ENTRIES = 16;
  localparam int EQC_ENTRIES = 8;
  localparam int MSG_ENTRIES = 8;
  localparam int DQR_PI_W = 5;
  localparam int MSG_PI_W = 4;
  localparam int EQC_CI_W = 4;
  localparam int WT_W = 4;
  localparam int TOP_WQS = 2;
  localparam int MID_BASE = 2;
  localparam int LOW_BASE = 5;
  localparam logic [1:0] MSG_ENQ_REJECT = 2'h0;
  localparam logic [1:0] MSG_RETIRED = 2'h1;
  localparam logic [1:0] MSG_VDQ_REJECT = 2'h2;

  // one frame, 16 bytes
  typedef struct packed {
    logic [1:0] trace;
    logic [5:0] part_id;
    logic [7:0] pool_id;
    logic [1:0] fmt;
    logic [8:0] offset;
    logic [19:0] length;
    logic [47:0] addr;
    logic [31:0] token;
    logic rsvd;
  } fd_t;

  typedef enum logic [1:0] {FQ_OOS, FQ_PARKED, FQ_SCHED, FQ_RETIRED} fq_state_t;
  typedef enum logic [1:0] {MG_INIT, MG_SCHED, MG_RETIRE, MG_QUERY} mgmt_verb_t;

  typedef struct packed {
    fd_t fd;
    logic [FQ_IDX_W-1:0] fq;
  } enq_cmd_t;

  typedef struct packed {
    fd_t fd;
    logic fd_valid;
    logic expired;
    logic one_shot;
    logic [2:0] wq;
    logic [FQ_IDX_W-1:0] fq;
    logic [31:0] ctx;
  } dqr_entry_t;

  typedef struct packed {
    logic [1:0] kind;
    logic [FQ_IDX_W-1:0] fq;
  } msg_t;

  typedef struct packed {
    mgmt_verb_t verb;
    logic [FQ_IDX_W-1:0] fq;
    logic [2:0] wq;
    logic stash;
    logic [31:0] ctx;
  } mgmt_cmd_t;

  typedef struct packed {
    logic chan_en;
    logic wq_once;
    logic [2:0] wq;
  } sdq_cmd_t;

  typedef struct packed {
    logic [FQ_IDX_W-1:0] fq;
    logic [7:0] count;
    logic favour;
  } vdq_cmd_t;

  typedef struct packed {
    logic [5:0][WT_W-1:0] wq_w;
    logic [WT_W-1:0] mid_w;
    logic [WT_W-1:0] low_w;
  } sched_wt_t;

  typedef struct packed {
    logic dqr_stash;
    logic data_stash;
  } stash_cfg_t;
endpackage : fqm_pkg

// *** wirr_tier.sv ***
// weighted interleaved round-robin over one tier of work queues
`timescale 1ns/1ns
module wirr_tier #(
  parameter int N = 3,
  parameter int WW = 4
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [N-1:0] ready,
  input wire logic [N-1:0][WW-1:0] weight,
  input wire logic take,
  output logic any,
  output logic [$clog2(N)-1:0] sel
);
  localparam int SW = $clog2(N);
  logic [SW-1:0] ptr_r;
  logic [WW-1:0] used_r;
  logic found;
  logic keep;
  int idx;

  // stay on the current member until its weight is spent, then move on
  always_comb begin
    found = 1'b0;
    idx = 0;
    any = |ready;
    keep = ready[ptr_r] && (used_r < weight[ptr_r]);
    sel = ptr_r;
    if (!keep) begin
      for (int k = 1; k <= N; k++) begin
        idx = (int'(ptr_r) + k) % N;
        if (!found && ready[idx]) begin
          sel = SW'(idx);
          found = 1'b1;
        end
      end
    end
  end

  // credit bookkeeping per grant
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ptr_r <= '0;
      used_r <= '0;
    end else if (take) begin
      if (keep) begin
        used_r <= used_r + WW'(1);
      end else begin
        ptr_r <= sel;
        used_r <= WW'(1);
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  a_grant_ready: assert property (take |-> ready[sel])
    else $error("tier granted a member with no work");
  a_turn_kept: assert property (take && keep |=> ptr_r == $past(ptr_r))
    else $error("tier left a member before its weight was spent");
endmodule : wirr_tier

// *** frame_queue_manager.sv ***
// frame queue manager portal: frame store, class scheduler, rings, commands
`timescale 1ns/1ns
// What this block does
// - frames held as 16-byte descriptors
// - 32-bit token passes through untouched
// - addresses used only for configured data stash
// - length always tracked per frame queue
// - descriptors copied into store, copied out
// - each frame queue is first-in first-out
// - frame queue index is store record index
// - non-empty scheduled queues link to work queues
// - channel groups exactly eight work queues
// - work queues 0,1 strict priority
// - work queues 2-4 weighted round-robin
// - work queues 5-7 weighted round-robin
// - tier weights and inter-tier weights programmable
// - portal owns one dedicated channel
// - enqueue ring of eight entries
// - dequeue ring of sixteen entries
// - response entries optionally stashed to cache
// - message ring of eight, never stashed
// - management command with two response words
// - one-shot dequeue only on parked/retired queues
// - scheduled dequeue: work queue, queue, frame
// - pull and push dequeue modes
// - push standing command runs only with work
// - one-shot expires with empty response entry
// - precedence bit picks one-shot or standing
module frame_queue_manager #(
  parameter int NUM_FQ = 16,
  parameter int FQ_DEPTH = 8
) (
  input wire logic CLK_SYS,
  input wire logic RESETN,
  input wire logic ENQ_VALID,
  input wire fqm_pkg::enq_cmd_t ENQ_CMD,
  output logic ENQ_READY,
  output logic [fqm_pkg::EQC_CI_W-1:0] ENQ_CI,
  input wire logic PUSH_MODE,
  input wire logic SDQ_WR,
  input wire fqm_pkg::sdq_cmd_t SDQ_CMD,
  input wire logic VDQ_WR,
  input wire fqm_pkg::vdq_cmd_t VDQ_CMD,
  output logic VDQ_ACTIVE,
  input wire fqm_pkg::sched_wt_t SCHED_WT,
  input wire fqm_pkg::stash_cfg_t STASH_CFG,
  output logic DQR_VALID,
  output fqm_pkg::dqr_entry_t DQR_ENTRY,
  output logic [fqm_pkg::DQR_PI_W-1:0] DQR_PI,
  input wire logic [fqm_pkg::DQR_PI_W-1:0] DQR_CI,
  output logic DQR_STASH,
  output logic DATA_STASH_VALID,
  output logic [47:0] DATA_STASH_ADDR,
  output logic MSG_VALID,
  output fqm_pkg::msg_t MSG_ENTRY,
  output logic [fqm_pkg::MSG_PI_W-1:0] MSG_PI,
  input wire logic [fqm_pkg::MSG_PI_W-1:0] MSG_CI,
  input wire logic MGMT_VALID,
  input wire fqm_pkg::mgmt_cmd_t MGMT_CMD,
  output logic MGMT_RESP_VALID,
  output logic [31:0] MGMT_RESP_A,
  output logic [31:0] MGMT_RESP_B
);
  localparam int FW = $clog2(NUM_FQ);
  localparam int DW = $clog2(FQ_DEPTH);

  // per-queue records; the index is the frame queue index
  fqm_pkg::fd_t store_r [NUM_FQ*FQ_DEPTH];
  fqm_pkg::fq_state_t st_r [NUM_FQ];
  logic [2:0] wq_r [NUM_FQ];
  logic [31:0] ctx_r [NUM_FQ];
  logic [31:0] bytes_r [NUM_FQ];
  logic [DW-1:0] head_r [NUM_FQ];
  logic [DW-1:0] tail_r [NUM_FQ];
  logic [DW:0] cnt_r [NUM_FQ];
  logic [NUM_FQ-1:0] stash_fq_r;
  logic [NUM_FQ-1:0] linked_r;

  logic enq_rdy_r, enq_take, enq_ok;
  logic [FW-1:0] enq_fq, mg_fq;
  localparam int EQC_CI_W_L = fqm_pkg::EQC_CI_W;
  logic [EQC_CI_W_L-1:0] eqc_ci_r;
  logic mg_ok;

  logic chan_en_r, once_r, pend_r;
  logic [2:0] once_wq_r;
  logic vdq_act_r, vdq_prec_r, vdq_legal;
  logic [FW-1:0] vdq_fq_r;
  logic [7:0] vdq_rem_r;

  logic [7:0] wq_rdy;
  logic mid_any, low_any, use_mid, take, take_mid, take_low;
  logic [1:0] mid_sel, low_sel;
  logic tier_r;
  logic [fqm_pkg::WT_W-1:0] tier_cnt_r;
  logic [2:0] sched_wq, tgt_wq;
  logic sched_ok, s_found, pick_v, pick_s, room, go, has_fd, deq;
  logic [FW-1:0] s_fq, dq_fq;
  fqm_pkg::fd_t dq_fd;

  logic dqr_v_r, dqr_stash_r, dstash_v_r;
  fqm_pkg::dqr_entry_t dqr_r;
  logic [fqm_pkg::DQR_PI_W-1:0] dqr_pi_r;
  logic [47:0] dstash_addr_r;
  logic msg_v_r, ret_pend_r, vrej_pend_r;
  fqm_pkg::msg_t msg_r;
  localparam int FQ_IDX_W_L = fqm_pkg::FQ_IDX_W;
  logic [FQ_IDX_W_L-1:0] ret_fq_r, vrej_fq_r;
  logic [fqm_pkg::MSG_PI_W-1:0] msg_pi_r;
  logic mresp_v_r;
  logic [31:0] mresp_a_r, mresp_b_r;

  // enqueue checks: queue exists, accepts enqueues, and has room
  assign enq_take = ENQ_VALID && enq_rdy_r;
  assign enq_fq = ENQ_CMD.fq[FW-1:0];
  assign enq_ok = enq_take && (int'(ENQ_CMD.fq) < NUM_FQ) && cnt_r[enq_fq] != (DW+1)'(FQ_DEPTH)
    && (st_r[enq_fq] == fqm_pkg::FQ_PARKED || st_r[enq_fq] == fqm_pkg::FQ_SCHED);
  assign mg_fq = MGMT_CMD.fq[FW-1:0];
  assign mg_ok = MGMT_VALID && (int'(MGMT_CMD.fq) < NUM_FQ);
  assign vdq_legal = (int'(VDQ_CMD.fq) < NUM_FQ) && (st_r[VDQ_CMD.fq[FW-1:0]] == fqm_pkg::FQ_PARKED
    || st_r[VDQ_CMD.fq[FW-1:0]] == fqm_pkg::FQ_RETIRED);

  // work queues of the portal's own channel with linked queues
  always_comb begin
    wq_rdy = '0;
    for (int i = 0; i < NUM_FQ; i++) begin
      if (linked_r[i]) wq_rdy[wq_r[i]] = 1'b1;
    end
  end

  wirr_tier #(.N(3), .WW(fqm_pkg::WT_W)) u_mid (
    .clk_sys(CLK_SYS),
    .resetn(RESETN),
    .ready(wq_rdy[4:2]),
    .weight(SCHED_WT.wq_w[2:0]),
    .take(take_mid),
    .any(mid_any),
    .sel(mid_sel)
  );

  wirr_tier #(.N(3), .WW(fqm_pkg::WT_W)) u_low (
    .clk_sys(CLK_SYS),
    .resetn(RESETN),
    .ready(wq_rdy[7:5]),
    .weight(SCHED_WT.wq_w[5:3]),
    .take(take_low),
    .any(low_any),
    .sel(low_sel)
  );

  // class scheduler: strict top tier, then weighted choice between tiers
  always_comb begin
    use_mid = mid_any && (!low_any || (tier_r == 1'b0 ? tier_cnt_r < SCHED_WT.mid_w
      : tier_cnt_r >= SCHED_WT.low_w));
    if (wq_rdy[0]) sched_wq = 3'h0;
    else if (wq_rdy[1]) sched_wq = 3'h1;
    else if (use_mid) sched_wq = 3'(fqm_pkg::MID_BASE) + {1'b0, mid_sel};
    else sched_wq = 3'(fqm_pkg::LOW_BASE) + {1'b0, low_sel};
  end

  // pick the source: standing command or one-shot, then queue and frame
  always_comb begin
    sched_ok = PUSH_MODE ? (once_r ? wq_rdy[once_wq_r] : (chan_en_r && |wq_rdy))
      : pend_r;
    tgt_wq = once_r ? once_wq_r : sched_wq;
    s_found = 1'b0;
    s_fq = '0;
    for (int i = NUM_FQ - 1; i >= 0; i--) begin
      if (linked_r[i] && wq_r[i] == tgt_wq) begin
        s_found = 1'b1;
        s_fq = FW'(i);
      end
    end
    pick_v = vdq_act_r && (!sched_ok || vdq_prec_r);
    pick_s = sched_ok && !pick_v;
    room = (dqr_pi_r - DQR_CI) != fqm_pkg::DQR_PI_W'(fqm_pkg::DQR_ENTRIES);
    go = room && (pick_v || pick_s);
    dq_fq = pick_v ? vdq_fq_r : s_fq;
    has_fd = pick_v ? (vdq_rem_r != 8'h00 && cnt_r[vdq_fq_r] != '0) : s_found;
    deq = go && has_fd;
    take = go && pick_s && !once_r && s_found;
    take_mid = take && !(|wq_rdy[1:0]) && use_mid;
    take_low = take && !(|wq_rdy[1:0]) && !use_mid && low_any;
    dq_fd = store_r[{dq_fq, head_r[dq_fq]}];
  end

  // inter-tier credit count
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      tier_r <= 1'b0;
      tier_cnt_r <= '0;
    end else if (take_mid || take_low) begin
      if (tier_r == take_low) begin
        tier_cnt_r <= tier_cnt_r + fqm_pkg::WT_W'(1);
      end else begin
        tier_r <= take_low;
        tier_cnt_r <= fqm_pkg::WT_W'(1);
      end
    end
  end

  // frame store writes: copy the whole descriptor in at the tail
  always_ff @(posedge CLK_SYS) begin
    if (enq_ok) store_r[{enq_fq, tail_r[enq_fq]}] <= ENQ_CMD.fd;
  end

  // per-queue pointers, counts, byte totals and work queue links
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      linked_r <= '0;
      for (int i = 0; i < NUM_FQ; i++) begin
        head_r[i] <= '0;
        tail_r[i] <= '0;
        cnt_r[i] <= '0;
        bytes_r[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NUM_FQ; i++) begin
        automatic logic e = enq_ok && enq_fq == FW'(i);
        automatic logic d = deq && dq_fq == FW'(i);
        automatic logic [DW:0] c = cnt_r[i] + (DW+1)'(e) - (DW+1)'(d);
        if (mg_ok && MGMT_CMD.verb == fqm_pkg::MG_INIT && mg_fq == FW'(i)) begin
          head_r[i] <= '0;
          tail_r[i] <= '0;
          cnt_r[i] <= '0;
          bytes_r[i] <= '0;
          linked_r[i] <= 1'b0;
        end else begin
          if (e) tail_r[i] <= tail_r[i] + DW'(1);
          if (d) head_r[i] <= head_r[i] + DW'(1);
          cnt_r[i] <= c;
          bytes_r[i] <= bytes_r[i] + (e ? 32'(ENQ_CMD.fd.length) : 32'h0)
            - (d ? 32'(dq_fd.length) : 32'h0);
          linked_r[i] <= st_r[i] == fqm_pkg::FQ_SCHED && c != '0;
        end
      end
    end
  end

  // management commands: queue state, work queue, context
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      stash_fq_r <= '0;
      for (int i = 0; i < NUM_FQ; i++) begin
        st_r[i] <= fqm_pkg::FQ_OOS;
        wq_r[i] <= 3'h0;
        ctx_r[i] <= 32'h0;
      end
    end else if (mg_ok) begin
      unique case (MGMT_CMD.verb)
        fqm_pkg::MG_INIT: begin
          st_r[mg_fq] <= fqm_pkg::FQ_PARKED;
          wq_r[mg_fq] <= MGMT_CMD.wq;
          ctx_r[mg_fq] <= MGMT_CMD.ctx;
          stash_fq_r[mg_fq] <= MGMT_CMD.stash;
        end
        fqm_pkg::MG_SCHED: begin
          if (st_r[mg_fq] == fqm_pkg::FQ_PARKED) st_r[mg_fq] <= fqm_pkg::FQ_SCHED;
        end
        fqm_pkg::MG_RETIRE: begin
          if (st_r[mg_fq] != fqm_pkg::FQ_OOS) st_r[mg_fq] <= fqm_pkg::FQ_RETIRED;
        end
        fqm_pkg::MG_QUERY: begin
        end
      endcase
    end
  end

  // management answer one cycle after the command
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      mresp_v_r <= 1'b0;
      mresp_a_r <= 32'h0;
      mresp_b_r <= 32'h0;
    end else begin
      mresp_v_r <= MGMT_VALID;
      if (MGMT_VALID) begin
        mresp_a_r <= mg_ok ? {16'h0, 3'(st_r[mg_fq]), wq_r[mg_fq], 1'b0, linked_r[mg_fq],
          8'(cnt_r[mg_fq])} : 32'hFFFFFFFF;
        mresp_b_r <= mg_ok ? bytes_r[mg_fq] : 32'h0;
      end
    end
  end

  // standing and one-shot dequeue command registers
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      chan_en_r <= 1'b0;
      once_r <= 1'b0;
      once_wq_r <= 3'h0;
      pend_r <= 1'b0;
      vdq_act_r <= 1'b0;
      vdq_prec_r <= 1'b0;
      vdq_fq_r <= '0;
      vdq_rem_r <= 8'h00;
    end else begin
      if (go && pick_s) begin
        once_r <= 1'b0;
        pend_r <= 1'b0;
      end
      if (SDQ_WR) begin
        chan_en_r <= SDQ_CMD.chan_en;
        once_r <= SDQ_CMD.wq_once;
        once_wq_r <= SDQ_CMD.wq;
        pend_r <= !PUSH_MODE;
      end
      if (go && pick_v) begin
        if (has_fd) vdq_rem_r <= vdq_rem_r - 8'h01;
        else vdq_act_r <= 1'b0;
      end
      if (VDQ_WR && !vdq_act_r && vdq_legal) begin
        vdq_act_r <= 1'b1;
        vdq_fq_r <= VDQ_CMD.fq[FW-1:0];
        vdq_rem_r <= VDQ_CMD.count;
        vdq_prec_r <= VDQ_CMD.favour;
      end
    end
  end

  // dequeue response ring producer and stash pushes
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      dqr_v_r <= 1'b0;
      dqr_r <= '0;
      dqr_pi_r <= '0;
      dqr_stash_r <= 1'b0;
      dstash_v_r <= 1'b0;
      dstash_addr_r <= 48'h0;
    end else begin
      dqr_v_r <= go;
      dqr_stash_r <= go && STASH_CFG.dqr_stash;
      dstash_v_r <= deq && STASH_CFG.data_stash && stash_fq_r[dq_fq];
      if (go) begin
        dqr_pi_r <= dqr_pi_r + fqm_pkg::DQR_PI_W'(1);
        dqr_r.fd <= has_fd ? dq_fd : '0;
        dqr_r.fd_valid <= has_fd;
        dqr_r.expired <= pick_v && !has_fd;
        dqr_r.one_shot <= pick_v;
        dqr_r.wq <= wq_r[dq_fq];
        dqr_r.fq <= fqm_pkg::FQ_IDX_W'(dq_fq);
        dqr_r.ctx <= ctx_r[dq_fq];
        if (has_fd) dstash_addr_r <= dq_fd.addr;
      end
    end
  end

  // enqueue ring consumer and message ring producer, no stash path
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      enq_rdy_r <= 1'b0;
      eqc_ci_r <= '0;
      msg_v_r <= 1'b0;
      msg_r <= '0;
      msg_pi_r <= '0;
      ret_pend_r <= 1'b0;
      vrej_pend_r <= 1'b0;
      ret_fq_r <= '0;
      vrej_fq_r <= '0;
    end else begin
      enq_rdy_r <= (msg_pi_r - MSG_CI) < fqm_pkg::MSG_PI_W'(fqm_pkg::MSG_ENTRIES - 2);
      if (enq_take) eqc_ci_r <= eqc_ci_r + EQC_CI_W_L'(1);
      msg_v_r <= 1'b0;
      if (enq_take && !enq_ok) begin
        msg_v_r <= 1'b1;
        msg_r <= '{kind: fqm_pkg::MSG_ENQ_REJECT, fq: ENQ_CMD.fq};
      end else if (ret_pend_r && msg_pi_r - MSG_CI != fqm_pkg::MSG_PI_W'(fqm_pkg::MSG_ENTRIES)) begin
        msg_v_r <= 1'b1;
        msg_r <= '{kind: fqm_pkg::MSG_RETIRED, fq: ret_fq_r};
        ret_pend_r <= 1'b0;
      end else if (vrej_pend_r && msg_pi_r - MSG_CI != fqm_pkg::MSG_PI_W'(fqm_pkg::MSG_ENTRIES)) begin
        msg_v_r <= 1'b1;
        msg_r <= '{kind: fqm_pkg::MSG_VDQ_REJECT, fq: vrej_fq_r};
        vrej_pend_r <= 1'b0;
      end
      if (msg_v_r) msg_pi_r <= msg_pi_r + fqm_pkg::MSG_PI_W'(1);
      // new events win over the clear
      if (mg_ok && MGMT_CMD.verb == fqm_pkg::MG_RETIRE && st_r[mg_fq] != fqm_pkg::FQ_OOS) begin
        ret_pend_r <= 1'b1;
        ret_fq_r <= MGMT_CMD.fq;
      end
      if (VDQ_WR && !vdq_act_r && !vdq_legal) begin
        vrej_pend_r <= 1'b1;
        vrej_fq_r <= VDQ_CMD.fq;
      end
    end
  end

  assign ENQ_READY = enq_rdy_r;
  assign ENQ_CI = eqc_ci_r;
  assign VDQ_ACTIVE = vdq_act_r;
  assign DQR_VALID = dqr_v_r;
  assign DQR_ENTRY = dqr_r;
  assign DQR_PI = dqr_pi_r;
  assign DQR_STASH = dqr_stash_r;
  assign DATA_STASH_VALID = dstash_v_r;
  assign DATA_STASH_ADDR = dstash_addr_r;
  assign MSG_VALID = msg_v_r;
  assign MSG_ENTRY = msg_r;
  assign MSG_PI = msg_pi_r;
  assign MGMT_RESP_VALID = mresp_v_r;
  assign MGMT_RESP_A = mresp_a_r;
  assign MGMT_RESP_B = mresp_b_r;

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RESETN);

  a_top_strict: assert property (take && wq_rdy[0] |-> sched_wq == 3'h0)
    else $error("work queue 0 not served first");
  a_top_second: assert property (take && wq_rdy[1:0] == 2'b10 |-> sched_wq == 3'h1)
    else $error("work queue 1 not served ahead of lower tiers");
  a_mid_range: assert property (take_mid |-> sched_wq inside {3'h2, 3'h3, 3'h4})
    else $error("middle tier grant outside work queues 2 to 4");
  a_low_range: assert property (take && wq_rdy[4:0] == 5'h00 |-> sched_wq >= 3'h5)
    else $error("lowest tier grant outside work queues 5 to 7");
  a_pi_step: assert property (DQR_VALID |-> DQR_PI == $past(DQR_PI) + 5'h01)
    else $error("producer index did not step with the entry");
  a_ring_bound: assert property ((DQR_PI - DQR_CI) <= 5'h10)
    else $error("response ring overfilled");
  a_vdq_legal: assert property ($rose(vdq_act_r) |-> $past(vdq_legal))
    else $error("one-shot dequeue started on a scheduled queue");
  a_vdq_expiry: assert property ($fell(vdq_act_r) |-> DQR_VALID && !DQR_ENTRY.fd_valid
    && DQR_ENTRY.expired)
    else $error("one-shot expiry without empty response entry");
  a_dqr_stash: assert property (DQR_STASH |-> DQR_VALID && $past(STASH_CFG.dqr_stash))
    else $error("stash push without a new entry");
  a_data_stash: assert property (DATA_STASH_VALID |-> DQR_VALID && DQR_ENTRY.fd_valid)
    else $error("data stash without a dequeued frame");
  a_mgmt_answer: assert property (MGMT_VALID |=> MGMT_RESP_VALID ##1 !MGMT_RESP_VALID
    || $past(MGMT_VALID))
    else $error("management command without one-cycle answer");
  a_push_has_fd: assert property (go && pick_s && PUSH_MODE |-> has_fd)
    else $error("push standing command ran without work");

  c_vdq_expiry: cover property ($fell(vdq_act_r));
  c_mid_grant: cover property (take_mid);
  c_enq_reject: cover property (MSG_VALID && MSG_ENTRY.kind == fqm_pkg::MSG_ENQ_REJECT);
  c_prec_clash: cover property (vdq_act_r && sched_ok && go);
endmodule : frame_queue_manager

// *** fqm_sw_portal.sv ***
// software side of the portal: consumes response and message ring entries
`timescale 1ns/1ns
module fqm_sw_portal (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic stall,
  input wire logic [fqm_pkg::DQR_PI_W-1:0] dqr_pi,
  input wire logic [fqm_pkg::MSG_PI_W-1:0] msg_pi,
  output logic [fqm_pkg::DQR_PI_W-1:0] dqr_ci,
  output logic [fqm_pkg::MSG_PI_W-1:0] msg_ci
);
  // one response a cycle while the producer is ahead; stall models slow software
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      dqr_ci <= '0;
    end else if (!stall && dqr_ci != dqr_pi) begin
      dqr_ci <= dqr_ci + 5'h01;
    end
  end
  // message ring drained the same way
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      msg_ci <= '0;
    end else if (!stall && msg_ci != msg_pi) begin
      msg_ci <= msg_ci + 4'h1;
    end
  end
endmodule : fqm_sw_portal

// *** frame_queue_manager_tb_top.sv ***
// testbench: frame queue manager portal driven against a software consumer
`timescale 1ns/1ns
module frame_queue_manager_tb_top;
  logic clk_sys, resetn, enq_valid, enq_ready, push_mode, sdq_wr, vdq_wr, vdq_active;
  logic dqr_valid, dqr_stash, dst_valid, msg_valid, mgmt_valid, mresp_valid, stall;
  logic [fqm_pkg::EQC_CI_W-1:0] enq_ci;
  logic [fqm_pkg::DQR_PI_W-1:0] dqr_pi, dqr_ci, pi0;
  logic [fqm_pkg::MSG_PI_W-1:0] msg_pi, msg_ci;
  logic [47:0] dst_addr, dst_seen;
  logic [31:0] resp_a, resp_b;
  logic [1:0] stash_cfg;
  fqm_pkg::enq_cmd_t enq_cmd;
  fqm_pkg::sdq_cmd_t sdq_cmd;
  fqm_pkg::vdq_cmd_t vdq_cmd;
  fqm_pkg::dqr_entry_t dqr_entry;
  fqm_pkg::msg_t msg_entry;
  fqm_pkg::mgmt_cmd_t mgmt_cmd;
  fqm_pkg::dqr_entry_t dq[$];
  fqm_pkg::msg_t mq[$];
  int fails, n_checks, n_ds, n_dd;

  frame_queue_manager #(.NUM_FQ(16), .FQ_DEPTH(8)) u_frame_queue_manager (
    .CLK_SYS(clk_sys), .RESETN(resetn), .ENQ_VALID(enq_valid), .ENQ_CMD(enq_cmd),
    .ENQ_READY(enq_ready), .ENQ_CI(enq_ci), .PUSH_MODE(push_mode), .SDQ_WR(sdq_wr),
    .SDQ_CMD(sdq_cmd), .VDQ_WR(vdq_wr), .VDQ_CMD(vdq_cmd), .VDQ_ACTIVE(vdq_active),
    .SCHED_WT(32'h11111111), .STASH_CFG(stash_cfg), .DQR_VALID(dqr_valid),
    .DQR_ENTRY(dqr_entry), .DQR_PI(dqr_pi), .DQR_CI(dqr_ci), .DQR_STASH(dqr_stash),
    .DATA_STASH_VALID(dst_valid), .DATA_STASH_ADDR(dst_addr), .MSG_VALID(msg_valid),
    .MSG_ENTRY(msg_entry), .MSG_PI(msg_pi), .MSG_CI(msg_ci), .MGMT_VALID(mgmt_valid),
    .MGMT_CMD(mgmt_cmd), .MGMT_RESP_VALID(mresp_valid), .MGMT_RESP_A(resp_a),
    .MGMT_RESP_B(resp_b));
  fqm_sw_portal u_fqm_sw_portal (.clk_sys(clk_sys), .resetn(resetn), .stall(stall),
    .dqr_pi(dqr_pi), .msg_pi(msg_pi), .dqr_ci(dqr_ci), .msg_ci(msg_ci));

  // 20 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // collect each ring entry in the cycle it stands
  always @(negedge clk_sys) begin
    if (dqr_valid === 1'b1) dq.push_back(dqr_entry);
    if (msg_valid === 1'b1) mq.push_back(msg_entry);
    if (dqr_stash === 1'b1) n_ds++;
    if (dst_valid === 1'b1) n_dd++;
    if (dst_valid === 1'b1) dst_seen = dst_addr;
  end

  task automatic chk(string what, logic [63:0] got, logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk
  task automatic report_and_stop();
    if (fails == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop
  // wait, bounded, until n responses (or messages) have arrived
  task automatic wait_q(int n, bit on_msg);
    for (int i = 0; i < 60 && (on_msg ? mq.size() : dq.size()) < n; i++) @(negedge clk_sys);
  endtask : wait_q
  task automatic mgmt(fqm_pkg::mgmt_verb_t verb, logic [7:0] fq, logic [2:0] wq, bit st = 1'b0);
    fqm_pkg::mgmt_cmd_t c;
    c = '0;
    c.verb = verb;
    c.fq = fq;
    c.wq = wq;
    c.stash = st;
    @(posedge clk_sys);
    mgmt_valid <= 1'b1;
    mgmt_cmd <= c;
    @(posedge clk_sys);
    mgmt_valid <= 1'b0;
    #1;
    chk("mgmt_resp_valid", mresp_valid, 1'h1);
  endtask : mgmt
  task automatic enq(logic [7:0] fq, logic [31:0] tok, logic [19:0] len);
    fqm_pkg::enq_cmd_t c;
    c = '0;
    c.fq = fq;
    c.fd.token = tok;
    c.fd.length = len;
    c.fd.addr = 48'(tok);
    @(posedge clk_sys);
    enq_valid <= 1'b1;
    enq_cmd <= c;
    @(negedge clk_sys);
    while (enq_ready !== 1'b1) @(negedge clk_sys);
    @(posedge clk_sys);
    enq_valid <= 1'b0;
  endtask : enq
  task automatic sdq();
    @(posedge clk_sys);
    sdq_wr <= 1'b1;
    sdq_cmd <= '{chan_en: 1'b1, wq_once: 1'b0, wq: 3'h0};
    @(posedge clk_sys);
    sdq_wr <= 1'b0;
  endtask : sdq
  task automatic vdq(logic [7:0] fq, logic [7:0] cnt);
    @(posedge clk_sys);
    vdq_wr <= 1'b1;
    vdq_cmd <= '{fq: fq, count: cnt, favour: 1'b0};
    @(posedge clk_sys);
    vdq_wr <= 1'b0;
  endtask : vdq

  // out-of-range index answers all ones, last index is a real queue
  task automatic t_index();
    mgmt(fqm_pkg::MG_QUERY, 8'h10, 3'h0);
    chk("resp_a_range", resp_a, 32'hFFFFFFFF);
    mgmt(fqm_pkg::MG_QUERY, 8'h0F, 3'h0);
    chk("resp_a_last", resp_a, 32'h0);
  endtask : t_index
  // enqueue to an uninitialised queue is taken and rejected by message
  task automatic t_reject();
    logic [3:0] ci0;
    ci0 = enq_ci;
    enq(8'h01, 32'h0BAD0001, 20'h00004);
    wait_q(1, 1'b1);
    chk("enq_ci", enq_ci, ci0 + 4'h1);
    chk("msg_kind", mq[0].kind, fqm_pkg::MSG_ENQ_REJECT);
    chk("msg_fq", mq[0].fq, 8'h01);
  endtask : t_reject
  // parked queue drained by a one-shot of two frames, then expiry entry
  task automatic t_one_shot();
    mgmt(fqm_pkg::MG_INIT, 8'h02, 3'h0);
    enq(8'h02, 32'hA5A50001, 20'h0000A);
    enq(8'h02, 32'hA5A50002, 20'h00014);
    repeat (3) @(negedge clk_sys);
    mgmt(fqm_pkg::MG_QUERY, 8'h02, 3'h0);
    chk("fq_count", resp_a[7:0], 8'h02);
    chk("fq_bytes", resp_b, 32'h0000001E);
    pi0 = dqr_pi;
    dq.delete();
    vdq(8'h02, 8'h02);
    wait_q(3, 1'b0);
    chk("first_token", dq[0].fd.token, 32'hA5A50001);
    chk("second_token", dq[1].fd.token, 32'hA5A50002);
    chk("second_fq", dq[1].fq, 8'h02);
    chk("exp_fd_valid", dq[2].fd_valid, 1'h0);
    chk("exp_flag", dq[2].expired, 1'h1);
    chk("vdq_active", vdq_active, 1'h0);
    chk("pi_step", 5'(dqr_pi - pi0), 5'h03);
  endtask : t_one_shot
  // one-shot against a scheduled queue is refused
  task automatic t_illegal();
    mgmt(fqm_pkg::MG_INIT, 8'h03, 3'h5);
    mgmt(fqm_pkg::MG_SCHED, 8'h03, 3'h5);
    mq.delete();
    vdq(8'h03, 8'h01);
    wait_q(1, 1'b1);
    chk("vdq_reject", mq[0].kind, fqm_pkg::MSG_VDQ_REJECT);
    mgmt(fqm_pkg::MG_RETIRE, 8'h02, 3'h0);
    wait_q(2, 1'b1);
    chk("retire_kind", mq[1].kind, fqm_pkg::MSG_RETIRED);
  endtask : t_illegal
  // pull dequeues follow class priority, then an empty entry; software stalled
  task automatic t_priority();
    mgmt(fqm_pkg::MG_INIT, 8'h04, 3'h1);
    mgmt(fqm_pkg::MG_SCHED, 8'h04, 3'h1);
    mgmt(fqm_pkg::MG_INIT, 8'h05, 3'h0);
    mgmt(fqm_pkg::MG_SCHED, 8'h05, 3'h0);
    enq(8'h03, 32'h0000D003, 20'h00008);
    enq(8'h04, 32'h0000C004, 20'h00008);
    enq(8'h05, 32'h0000E005, 20'h00008);
    repeat (4) @(negedge clk_sys);
    dq.delete();
    stall <= 1'b1;
    for (int k = 1; k <= 4; k++) begin
      sdq();
      wait_q(k, 1'b0);
    end
    chk("wq_first", dq[0].wq, 3'h0);
    chk("wq_second", dq[1].wq, 3'h1);
    chk("wq_third", dq[2].wq, 3'h5);
    chk("fq_third", dq[2].fq, 8'h03);
    chk("empty_pull", dq[3].fd_valid, 1'h0);
    chk("ring_fill", 5'(dqr_pi - dqr_ci), 5'h04);
    stall <= 1'b0;
  endtask : t_priority
  // push mode runs the standing command only when work is linked
  task automatic t_push();
    push_mode <= 1'b1;
    sdq();
    repeat (10) @(negedge clk_sys);
    dq.delete();
    repeat (10) @(negedge clk_sys);
    chk("push_idle", dq.size(), 64'h0);
    stash_cfg <= 2'h3;
    enq(8'h04, 32'h0000F004, 20'h00010);
    wait_q(1, 1'b0);
    repeat (10) @(negedge clk_sys);
    chk("push_count", dq.size(), 64'h1);
    chk("push_token", dq[0].fd.token, 32'h0000F004);
    chk("dqr_stash", n_ds, 64'h1);
    chk("no_dstash", n_dd, 64'h0);
    mgmt(fqm_pkg::MG_INIT, 8'h06, 3'h2, 1'b1);
    mgmt(fqm_pkg::MG_SCHED, 8'h06, 3'h2);
    enq(8'h06, 32'h0000A006, 20'h00010);
    wait_q(2, 1'b0);
    chk("data_stash", n_dd, 64'h1);
    chk("stash_addr", dst_seen, 48'h00000000A006);
  endtask : t_push

  // watchdog: the run needs well under 4000 cycles
  initial begin
    #200000;
    fails++;
    report_and_stop();
  end
  // reset, then each scenario in turn
  initial begin
    resetn = 1'b0;
    {enq_valid, push_mode, sdq_wr, vdq_wr, mgmt_valid, stall, stash_cfg} = '0;
    enq_cmd = '0;
    sdq_cmd = '0;
    vdq_cmd = '0;
    mgmt_cmd = '0;
    repeat (20) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (2) @(negedge clk_sys);
    chk("enq_ready", enq_ready, 1'h1);
    chk("dqr_pi", dqr_pi, 5'h00);
    t_index();
    t_reject();
    t_one_shot();
    t_illegal();
    t_priority();
    t_push();
    report_and_stop();
  end
endmodule : frame_queue_manager_tb_top
